// >>> rtl/fpr_pkg.sv
// constants and types for the fan pwm ramp configuration block
package fpr_pkg;

  // ****************************************
  // register offsets (byte addresses = 4 x index)
  // ****************************************
  localparam logic [7:0] FPR_IDX_SPAN1   = 8'h5F;
  localparam logic [7:0] FPR_IDX_SPAN2   = 8'h60;
  localparam logic [7:0] FPR_IDX_SPAN3   = 8'h61;
  localparam logic [7:0] FPR_IDX_ACOU1   = 8'h62;
  localparam logic [7:0] FPR_IDX_REMOTE2_RAMP_RATE   = 8'h63;
  localparam logic [7:0] FPR_IDX_FLOOR1  = 8'h64;
  localparam logic [7:0] FPR_IDX_FLOOR2  = 8'h65;
  localparam logic [7:0] FPR_IDX_FLOOR3  = 8'h66;
  localparam logic [7:0] FPR_IDX_CFG6    = 8'h10;
  localparam logic [7:0] FPR_IDX_CTRL    = 8'h80;
  localparam logic [7:0] FPR_IDX_TEMP    = 8'h81;
  localparam logic [7:0] FPR_IDX_STAT0   = 8'h82;
  localparam logic [7:0] FPR_IDX_STAT1   = 8'h83;
  localparam logic [7:0] FPR_IDX_STAT2   = 8'h84;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] FPR_RST_SPAN    = 8'hC4;
  localparam logic [7:0] FPR_RST_REMOTE1_RAMP_RATE    = 8'h00;
  localparam logic [7:0] FPR_RST_FLOOR   = 8'h80;
  localparam logic [7:0] FPR_RST_CFG6    = 8'h00;
  localparam logic [7:0] FPR_RST_TEMP    = 8'h5A;
  localparam logic [8:0] FPR_RST_CTRL    = 9'h0DB;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FPR_RATE_LSB     = 0;
  localparam int FPR_BAND_BIT     = 3;
  localparam int FPR_SPAN_LSB     = 4;
  localparam int FPR_SYNC_BIT     = 4;
  localparam int FPR_FLOOR_LSB    = 5;
  localparam int FPR_SLOW_BIT     = 7;
  localparam int FPR_LOCK_BIT     = 0;
  localparam int FPR_BHV_LSB      = 1;
  localparam int FPR_CTRL_W       = 10;
  localparam int FPR_REMOTE2_RAMP_RATE_RR_LSB = 4;
  localparam int FPR_REMOTE2_RAMP_RATE_EN_BIT = 7;

  // ****************************************
  // timing: full 0..100% traverse at increment 1
  // ****************************************
  localparam int  FPR_CLK_HZ        = 250_000_000;
  localparam real FPR_TRAV_FAST_S   = 37.5;
  localparam real FPR_TRAV_SLOW_S   = 52.2;
  localparam int  FPR_DUTY_STEPS    = 255;
  localparam int  FPR_TICK_FAST     = int'($floor(FPR_TRAV_FAST_S * FPR_CLK_HZ / FPR_DUTY_STEPS));
  localparam int  FPR_TICK_SLOW     = int'($floor(FPR_TRAV_SLOW_S * FPR_CLK_HZ / FPR_DUTY_STEPS));
  localparam int  FPR_SLOW_FACTOR   = 4;

  // low-frequency pwm rates, in millihertz
  localparam int FPR_LF_MHZ [8] = '{11000, 14700, 22100, 29400, 35300, 44100, 58800, 88200};
  localparam int FPR_HF_HZ       = 22500;

  // behaviour codes
  localparam logic [2:0] FPR_BHV_R1   = 3'h0;
  localparam logic [2:0] FPR_BHV_LOC  = 3'h1;
  localparam logic [2:0] FPR_BHV_R2   = 3'h2;
  localparam logic [2:0] FPR_BHV_FULL = 3'h3;
  localparam logic [2:0] FPR_BHV_OFF  = 3'h4;
  localparam logic [2:0] FPR_BHV_MX2  = 3'h5;
  localparam logic [2:0] FPR_BHV_MX3  = 3'h6;
  localparam logic [2:0] FPR_BHV_MAN  = 3'h7;

  typedef enum logic [1:0] {FPR_APB_IDLE, FPR_APB_ACC} fpr_apb_e;

endpackage

// >>> rtl/fpr_pwm_out.sv
// one pwm output: period counter and comparator
`timescale 1ns/10ps
`default_nettype none
module fpr_pwm_out
  import fpr_pkg::*;
#(
  parameter int CLK_HZ = FPR_CLK_HZ
) (
  // clock, reset, enable
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ce,
  // control
  input  wire logic [2:0] i_rate,
  input  wire logic       i_band_hi,
  input  wire logic [7:0] i_duty,
  // pin
  output logic            o_pwm
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        pwm;
  } fpr_po_s;

  fpr_po_s st_reg;
  fpr_po_s st_next;
  logic [31:0] period;
  logic [39:0] thresh;

  // period in clocks of one full pwm frame
  function automatic logic [31:0] frame_clks(input logic [2:0] rate, input logic hi);
    longint t;
    if (hi)
      t = longint'(CLK_HZ) / FPR_HF_HZ;
    else
      t = longint'(CLK_HZ) * 1000 / FPR_LF_MHZ[rate];
    return t[31:0];
  endfunction

  always_comb begin
    period  = frame_clks(i_rate, i_band_hi);
    thresh  = 40'(period) * 40'(i_duty) / 40'd255;
    st_next = st_reg;
    if (st_reg.cnt + 32'h1 >= period)
      st_next.cnt = 32'h0;
    else
      st_next.cnt = st_reg.cnt + 32'h1;
    st_next.pwm = (40'(st_reg.cnt) < thresh);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst)
      st_reg <= '0;
    else if (i_ce)
      st_reg <= st_next;
  end

  assign o_pwm = st_reg.pwm;

endmodule
`default_nettype wire

// >>> rtl/fpr_top.sv
// fan pwm configuration, ramp limiting and drive for three channels
// Contract
// - rate code sets low-frequency pwm frequency
// - span/rate bit 3 selects high frequency
// - span code sets duty ramp temperature range
// - lock bit blocks writes to span, floor and acoustic registers
// - smoothing ramps duty instead of jumping
// - remote 1 ramp code sets step increment
// - slow bit stretches every traverse time
// - per-source bit slows ramp four times more
// - acoustic one bit 3 enables remote 1 smoothing
// - acoustic one bit 4 gates speed input two; three and four stay gated
// - floor bits pick off or minimum below start
// - acoustic two low bits configure local channel
// - acoustic two high bits configure remote 2
// - minimum duty maps linearly zero to full
// - behaviour field selects source or fixed mode
// - above start, run at minimum and climb
`timescale 1ns/10ps
`default_nettype none
module fpr_top
  import fpr_pkg::*;
#(
  parameter int TICK_FAST = FPR_TICK_FAST,
  parameter int TICK_SLOW = FPR_TICK_SLOW,
  parameter int CLK_HZ    = FPR_CLK_HZ
) (
  // clock, reset, enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // measured temperatures and hysteresis, same clock
  input  wire logic [7:0]  i_temp_r1,
  input  wire logic [7:0]  i_temp_loc,
  input  wire logic [7:0]  i_temp_r2,
  input  wire logic [3:0]  i_hyst_r1,
  input  wire logic [3:0]  i_hyst_loc,
  input  wire logic [3:0]  i_hyst_r2,
  // fan outputs
  output logic [2:0]       o_pwm,
  output logic             o_speed_in_two_gated,
  output logic             o_speed_in_three_gated,
  output logic             o_speed_in_four_gated
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0][7:0]  span;
    logic [7:0]       acou1;
    logic [7:0]       remote2_ramp_rate;
    logic [2:0][7:0]  floor;
    logic [7:0]       cfg6;
    logic             lock;
    logic [2:0][2:0]  bhv;
    logic [2:0][7:0]  tstart;
    logic [2:0]       active;
    logic [2:0][7:0]  duty;
    logic [2:0][31:0] tick;
    logic [31:0]      rdata;
    logic             slverr;
    fpr_apb_e         ph;
  } fpr_st_s;

  fpr_st_s st_reg;
  fpr_st_s st_next;

  // ****************************************
  // helper functions
  // ****************************************
  // span code to range in quarter degrees (2..80 C)
  function automatic logic [9:0] span_q(input logic [3:0] c);
    logic [9:0] r;
    unique case (c)
      4'h0: r = 10'd8;
      4'h1: r = 10'd10;
      4'h2: r = 10'd13;
      4'h3: r = 10'd16;
      4'h4: r = 10'd20;
      4'h5: r = 10'd27;
      4'h6: r = 10'd32;
      4'h7: r = 10'd40;
      4'h8: r = 10'd53;
      4'h9: r = 10'd64;
      4'hA: r = 10'd80;
      4'hB: r = 10'd107;
      4'hC: r = 10'd128;
      4'hD: r = 10'd160;
      4'hE: r = 10'd213;
      default: r = 10'd320;
    endcase
    return r;
  endfunction

  // ramp code to per-tick duty increment
  function automatic logic [7:0] ramp_inc(input logic [2:0] c);
    logic [7:0] r;
    unique case (c)
      3'h0: r = 8'd1;
      3'h1: r = 8'd2;
      3'h2: r = 8'd3;
      3'h3: r = 8'd4;
      3'h4: r = 8'd8;
      3'h5: r = 8'd12;
      3'h6: r = 8'd24;
      default: r = 8'd48;
    endcase
    return r;
  endfunction

  // automatic duty for one temperature channel
  function automatic logic [7:0] auto_duty(input logic [7:0] t, input logic [7:0] ts,
                                           input logic [3:0] sc, input logic [7:0] fl);
    logic [17:0] over;
    logic [17:0] add;
    logic [17:0] sum;
    over = 18'(t - ts) << 2;
    add  = 18'(over * 18'(8'hFF - fl)) / 18'(span_q(sc));
    sum  = 18'(fl) + add;
    if (t <= ts)
      return fl;
    else if (sum > 18'h0FF)
      return 8'hFF;
    else
      return sum[7:0];
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  // ****************************************
  // per-source targets and ramp settings
  // ****************************************
  logic [2:0][7:0] t_src;
  logic [2:0][3:0] h_src;
  logic [2:0][2:0] rr_src;
  logic [2:0]      sm_src;
  logic [2:0][7:0] tgt;
  logic [2:0][7:0] pwm_duty;
  logic [2:0]      src_idx;
  logic            wr_acc;
  logic            rd_acc;
  logic [9:0]      idx;
  logic            hit;

  always_comb begin
    t_src  = {i_temp_r2, i_temp_loc, i_temp_r1};
    h_src  = {i_hyst_r2, i_hyst_loc, i_hyst_r1};
    rr_src = {st_reg.remote2_ramp_rate[FPR_REMOTE2_RAMP_RATE_RR_LSB +: 3], st_reg.remote2_ramp_rate[2:0], st_reg.acou1[2:0]};
    sm_src = {st_reg.remote2_ramp_rate[FPR_REMOTE2_RAMP_RATE_EN_BIT], st_reg.remote2_ramp_rate[3],
              st_reg.acou1[3]};
  end

  // ****************************************
  // apb decode
  // ****************************************
  always_comb begin
    idx    = i_paddr[11:2];
    wr_acc = i_psel & i_penable & i_pwrite & i_ce;
    rd_acc = i_psel & i_penable & ~i_pwrite & i_ce;
    hit    = (idx >= 10'(FPR_IDX_SPAN1) && idx <= 10'(FPR_IDX_FLOOR3)) ||
             idx == 10'(FPR_IDX_CFG6) || (idx >= 10'(FPR_IDX_CTRL) && idx <= 10'(FPR_IDX_STAT2));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0]  cand [3];
    logic [7:0]  ch_t;
    logic [7:0]  inc;
    logic [31:0] lim;
    logic        above;
    logic        below;
    logic [7:0]  d;
    logic        lwr;
    logic [7:0]  wb;
    for (int k = 0; k < 3; k++)
      cand[k] = 8'h00;
    ch_t  = 8'h00;
    inc   = 8'h00;
    lim   = 32'h0;
    above = 1'b0;
    below = 1'b0;
    d     = 8'h00;
    lwr   = 1'b0;
    st_next = st_reg;
    src_idx = 3'h0;
    tgt     = '0;
    wb      = i_pstrb[0] ? i_pwdata[7:0] : 8'h00;

    // start/stop hysteresis per temperature source
    for (int s = 0; s < 3; s++) begin
      above = t_src[s] > st_reg.tstart[s];
      below = t_src[s] <= st_reg.tstart[s] - 8'(h_src[s]);
      if (above)
        st_next.active[s] = 1'b1;
      else if (below)
        st_next.active[s] = 1'b0;
    end

    // channel targets by behaviour
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 3; s++) begin
        if (st_reg.active[s])
          cand[s] = auto_duty(t_src[s], st_reg.tstart[s],
                              st_reg.span[c][FPR_SPAN_LSB +: 4], st_reg.floor[c]);
        else
          cand[s] = st_reg.acou1[FPR_FLOOR_LSB + c] ? st_reg.floor[c] : 8'h00;
      end
      unique case (st_reg.bhv[c])
        FPR_BHV_R1:   begin tgt[c] = cand[0]; src_idx = 3'd0; end
        FPR_BHV_LOC:  begin tgt[c] = cand[1]; src_idx = 3'd1; end
        FPR_BHV_R2:   begin tgt[c] = cand[2]; src_idx = 3'd2; end
        FPR_BHV_FULL: begin tgt[c] = 8'hFF;   src_idx = 3'd4; end
        FPR_BHV_OFF:  begin tgt[c] = 8'h00;   src_idx = 3'd4; end
        FPR_BHV_MX2:  begin
          tgt[c] = max8(cand[1], cand[2]);
          src_idx = (cand[2] > cand[1]) ? 3'd2 : 3'd1;
        end
        FPR_BHV_MX3:  begin
          tgt[c] = max8(cand[0], max8(cand[1], cand[2]));
          src_idx = (tgt[c] == cand[0]) ? 3'd0 : ((tgt[c] == cand[1]) ? 3'd1 : 3'd2);
        end
        FPR_BHV_MAN:  begin tgt[c] = st_reg.duty[c]; src_idx = 3'd4; end
      endcase

      // ramp toward target when the owning source has smoothing on
      d = st_reg.duty[c];
      if (src_idx < 3'd3 && sm_src[src_idx[1:0]]) begin
        inc = ramp_inc(rr_src[src_idx[1:0]]);
        lim = st_reg.cfg6[FPR_SLOW_BIT] ? 32'(TICK_SLOW) : 32'(TICK_FAST);
        if (st_reg.cfg6[src_idx[1:0]])
          lim = lim * 32'(FPR_SLOW_FACTOR);
        if (st_reg.tick[c] + 32'h1 >= lim) begin
          st_next.tick[c] = 32'h0;
          if (d < tgt[c])
            d = (8'hFF - d < inc || d + inc > tgt[c]) ? tgt[c] : d + inc;
          else if (d > tgt[c])
            d = (d < inc || d - inc < tgt[c]) ? tgt[c] : d - inc;
        end else begin
          st_next.tick[c] = st_reg.tick[c] + 32'h1;
        end
      end else begin
        st_next.tick[c] = 32'h0;
        if (st_reg.bhv[c] != FPR_BHV_MAN)
          d = tgt[c];
      end
      st_next.duty[c] = d;
    end

    // register writes take effect in the access phase
    st_next.ph     = (i_psel & ~i_penable) ? FPR_APB_ACC : FPR_APB_IDLE;
    lwr = wr_acc & ~st_reg.lock;
    if (wr_acc && i_pstrb[0]) begin
      if (lwr) begin
        for (int c = 0; c < 3; c++) begin
          if (idx == 10'(FPR_IDX_SPAN1) + 10'(c))
            st_next.span[c] = wb;
          if (idx == 10'(FPR_IDX_FLOOR1) + 10'(c))
            st_next.floor[c] = wb;
        end
        if (idx == 10'(FPR_IDX_ACOU1))
          st_next.acou1 = wb;
        if (idx == 10'(FPR_IDX_REMOTE2_RAMP_RATE))
          st_next.remote2_ramp_rate = wb;
      end
      if (idx == 10'(FPR_IDX_CFG6))
        st_next.cfg6 = wb;
      if (idx == 10'(FPR_IDX_CTRL)) begin
        st_next.lock = st_reg.lock | i_pwdata[FPR_LOCK_BIT];
        for (int c = 0; c < 3; c++)
          st_next.bhv[c] = i_pwdata[FPR_BHV_LSB + 3 * c +: 3];
      end
      if (idx == 10'(FPR_IDX_TEMP))
        st_next.tstart = i_pwdata[23:0];
      for (int c = 0; c < 3; c++)
        if (idx == 10'(FPR_IDX_STAT0) + 10'(c) && st_reg.bhv[c] == FPR_BHV_MAN)
          st_next.duty[c] = wb;
    end

    // read data is registered at setup so it is ready in the access phase
    st_next.slverr = 1'b0;
    if (i_psel && !i_penable) begin
      st_next.rdata  = 32'h0;
      st_next.slverr = ~hit;
      for (int c = 0; c < 3; c++) begin
        if (idx == 10'(FPR_IDX_SPAN1) + 10'(c))
          st_next.rdata = {24'h0, st_reg.span[c]};
        if (idx == 10'(FPR_IDX_FLOOR1) + 10'(c))
          st_next.rdata = {24'h0, st_reg.floor[c]};
        if (idx == 10'(FPR_IDX_STAT0) + 10'(c))
          st_next.rdata = {23'h0, st_reg.active[c], st_reg.duty[c]};
      end
      if (idx == 10'(FPR_IDX_ACOU1))
        st_next.rdata = {24'h0, st_reg.acou1};
      if (idx == 10'(FPR_IDX_REMOTE2_RAMP_RATE))
        st_next.rdata = {24'h0, st_reg.remote2_ramp_rate};
      if (idx == 10'(FPR_IDX_CFG6))
        st_next.rdata = {24'h0, st_reg.cfg6};
      if (idx == 10'(FPR_IDX_CTRL))
        st_next.rdata = {22'h0, st_reg.bhv, st_reg.lock};
      if (idx == 10'(FPR_IDX_TEMP))
        st_next.rdata = {8'h0, st_reg.tstart};
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg        <= '0;
      st_reg.span   <= {3{FPR_RST_SPAN}};
      st_reg.acou1  <= FPR_RST_REMOTE1_RAMP_RATE;
      st_reg.remote2_ramp_rate  <= FPR_RST_REMOTE1_RAMP_RATE;
      st_reg.floor  <= {3{FPR_RST_FLOOR}};
      st_reg.cfg6   <= FPR_RST_CFG6;
      st_reg.bhv    <= FPR_RST_CTRL;
      st_reg.tstart <= {3{FPR_RST_TEMP}};
      st_reg.ph     <= FPR_APB_IDLE;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // pwm drive and speed gating
  // ****************************************
  assign pwm_duty = st_reg.duty;

  for (genvar g = 0; g < 3; g++) begin : g_pwm
    fpr_pwm_out #(
      .CLK_HZ (CLK_HZ)
    ) u_pwm (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_rate    (st_reg.span[g][FPR_RATE_LSB +: 3]),
      .i_band_hi (st_reg.span[g][FPR_BAND_BIT]),
      .i_duty    (pwm_duty[g]),
      .o_pwm     (o_pwm[g])
    );
  end

  // gated inputs are measured only while pwm3 drives
  assign o_speed_in_two_gated   = st_reg.acou1[FPR_SYNC_BIT];
  assign o_speed_in_three_gated = 1'b1;
  assign o_speed_in_four_gated  = 1'b1;

  // ****************************************
  // apb outputs
  // ****************************************
  assign o_pready  = (st_reg.ph == FPR_APB_ACC);
  assign o_prdata  = st_reg.rdata;
  assign o_pslverr = st_reg.slverr & o_pready & i_psel & i_penable;

endmodule
`default_nettype wire

// >>> verification/fpr_fan_model.sv
// behavioural fan that measures the period and high time of its drive
`timescale 1ns/10ps
`default_nettype none
module fpr_fan_model (
  // clock
  input  wire logic   i_clk_sys,
  // drive from the block
  input  wire logic   i_pwm,
  // shape of the last complete drive period, in clocks
  output logic [31:0] o_period,
  output logic [31:0] o_high
);
  // ****************************************
  // period meter
  // ****************************************
  logic [31:0] cnt = 32'h0;
  logic [31:0] hcnt = 32'h0;
  logic        last = 1'b0;
  initial o_period = 32'h0;
  initial o_high = 32'h0;
  // a steady level reports nothing new: the fan only sees whole cycles
  always @(posedge i_clk_sys) begin
    if (i_pwm && !last) begin
      o_period <= cnt;
      o_high <= hcnt;
      cnt <= 32'h1;
      hcnt <= 32'h1;
    end else begin
      cnt <= cnt + 32'h1;
      hcnt <= hcnt + {31'h0, i_pwm};
    end
    last <= i_pwm;
  end
endmodule
`default_nettype wire

// >>> verification/fpr_top_monitor.sv
// assertion checker for the fan pwm ramp configuration block
`timescale 1ns/10ps
`default_nettype none
module fpr_top_monitor
  import fpr_pkg::*;
#(
  parameter int TICK_FAST = FPR_TICK_FAST,
  parameter int TICK_SLOW = FPR_TICK_SLOW,
  parameter int CLK_HZ    = FPR_CLK_HZ
) (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // fan side
  input wire logic [2:0]  o_pwm,
  input wire logic        o_speed_in_two_gated,
  input wire logic        o_speed_in_three_gated,
  input wire logic        o_speed_in_four_gated
);
  // ****************************************
  // helpers
  // ****************************************
  logic [9:0] idx_w;
  logic       wr_w;
  logic       map_w;
  logic       lock_reg;
  assign idx_w = i_paddr[11:2];
  assign wr_w = i_psel && i_penable && o_pready && i_pwrite;
  assign map_w = (idx_w >= 10'h05F && idx_w <= 10'h066) || idx_w == 10'h010
                 || (idx_w >= 10'h080 && idx_w <= 10'h084);
  // lock is sticky, so the shadow only clears at reset
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) lock_reg <= 1'b0;
    else if (wr_w && idx_w == 10'h080 && i_pwdata[0]) lock_reg <= 1'b1;
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  setup_then_ready_a : assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in the cycle after setup");
  ready_single_a : assert property (o_pready |=> !o_pready)
    else $error("ready held past one access cycle");
  err_with_ready_a : assert property (o_pslverr |-> o_pready)
    else $error("error flag without ready");
  unmapped_err_a : assert property (i_psel && i_penable && o_pready && !map_w |-> o_pslverr)
    else $error("unmapped access not flagged");
  mapped_ok_a : assert property (i_psel && i_penable && o_pready && map_w |-> !o_pslverr)
    else $error("mapped access flagged as error");
  gate_follows_a : assert property (wr_w && idx_w == 10'h062 && !lock_reg
    |=> o_speed_in_two_gated == $past(i_pwdata[4])) else $error("speed gate not updated");
  gate_locked_a : assert property (wr_w && idx_w == 10'h062 && lock_reg
    |=> $stable(o_speed_in_two_gated)) else $error("locked write changed speed gate");
  gate_fixed_a : assert property (o_speed_in_three_gated && o_speed_in_four_gated)
    else $error("speed inputs three and four not gated");
  full_at_start_a : assert property ($fell(i_sys_rst) |-> ##[1:20] o_pwm == 3'b111)
    else $error("fans not at full drive after reset");
  cover property (wr_w && lock_reg);
  cover property (o_pslverr);
  cover property (o_speed_in_two_gated);
endmodule
bind fpr_top fpr_top_monitor #(.TICK_FAST(TICK_FAST), .TICK_SLOW(TICK_SLOW), .CLK_HZ(CLK_HZ))
  mon_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pwm(o_pwm),
  .o_speed_in_two_gated(o_speed_in_two_gated),
  .o_speed_in_three_gated(o_speed_in_three_gated),
  .o_speed_in_four_gated(o_speed_in_four_gated));
`default_nettype wire

// >>> verification/test_fan_pwm_ramp_config.sv
// self-checking bench for the fan pwm ramp configuration block
`timescale 1ns/10ps
`default_nettype none
module test_fan_pwm_ramp_config;
  import fpr_pkg::*;
  // ****************************************
  // design and fans
  // ****************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  t1 = 8'h40;
  logic [7:0]  t2 = 8'h40;
  logic [7:0]  t3 = 8'h40;
  logic        ce = 1'b1;
  logic [3:0]  hy = 4'h4;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pwm;
  logic        gate2;
  logic        gate3;
  logic        gate4;
  logic [2:0]  g_s;
  logic [31:0] per [3];
  logic [31:0] hi [3];
  logic [31:0] rd_q;
  logic        err_q;
  int          mismatches = 0;
  int          total_checks = 0;
  int          incs [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  logic [7:0]  rst_v [8] = '{8'hC4, 8'hC4, 8'hC4, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
  logic [7:0]  beh_v [7] = '{8'hDF, 8'h9F, 8'hBF, 8'hFF, 8'h00, 8'hBF, 8'hDF};
  always #2 clk = ~clk;
  // gate levels are taken mid-cycle so they never race the edge
  always @(negedge clk) g_s <= {gate2, gate3, gate4};
  // scaled clock rate keeps a low-frequency period within the run
  fpr_top #(.TICK_FAST(4), .TICK_SLOW(6), .CLK_HZ(1_000_000)) dut_u (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_temp_r1(t1),
    .i_temp_loc(t2), .i_temp_r2(t3), .i_hyst_r1(hy), .i_hyst_loc(hy),
    .i_hyst_r2(hy), .o_pwm(pwm), .o_speed_in_two_gated(gate2),
    .o_speed_in_three_gated(gate3), .o_speed_in_four_gated(gate4));
  for (genvar g = 0; g < 3; g++) begin : fan_g
    fpr_fan_model fan_u (.i_clk_sys(clk), .i_pwm(pwm[g]), .o_period(per[g]), .o_high(hi[g]));
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic inr(input logic [31:0] v, input int lo, input int hb);
    chk({31'h0, (v >= lo && v <= hb)}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // ready comes from a register, so at the edge it still shows what the slave sampled
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    apb(1'b1, ix, {24'h0, v});
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    repeat (3) @(posedge clk);
    apb(1'b0, ix, 32'h0);
    chk({24'h0, rd_q[7:0]}, {24'h0, e});
  endtask
  task automatic temps(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    t1 <= a;
    t2 <= b;
    t3 <= c;
  endtask
  function automatic int mn(input int a);
    return a > 255 ? 255 : a;
  endfunction
  // fan starts off, then the source jumps far above start; duty must climb in steps
  task automatic ramp(input int ch, input logic [7:0] ai, input logic [7:0] av,
                      input logic [7:0] c6, input int inc, input int dv);
    int k;
    k = 240 / dv;
    temps(8'h40, 8'h40, 8'h40);
    wr(FPR_IDX_ACOU1, 8'h00);
    wr(FPR_IDX_REMOTE2_RAMP_RATE, 8'h00);
    wr(FPR_IDX_CFG6, c6);
    wr(ai, av);
    temps(8'h6A, 8'h6A, 8'h6A);
    repeat (240) @(posedge clk);
    apb(1'b0, 8'(FPR_IDX_STAT0 + ch), 32'h0);
    inr({24'h0, rd_q[7:0]}, mn((k - 1) * inc), mn((k + 2) * inc));
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdc(8'(FPR_IDX_SPAN1 + i), rst_v[i]);
    for (int i = 0; i < 3; i++) rdc(8'(FPR_IDX_STAT0 + i), 8'hFF);
    apb(1'b0, 8'h3F, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    $display("test reset values done");
    temps(8'h72, 8'h62, 8'h6A);
    for (int b = 0; b < 7; b++) begin
      apb(1'b1, FPR_IDX_CTRL, 32'h1B0 | 32'(b << 1));
      rdc(FPR_IDX_STAT0, beh_v[b]);
    end
    apb(1'b1, FPR_IDX_CTRL, 32'h110);
    wr(FPR_IDX_SPAN1, 8'hF4);
    rdc(FPR_IDX_STAT0, 8'hA6);
    wr(FPR_IDX_SPAN1, 8'h04);
    rdc(FPR_IDX_STAT0, 8'hFF);
    wr(FPR_IDX_SPAN1, 8'hC4);
    wr(FPR_IDX_FLOOR1, 8'h40);
    rdc(FPR_IDX_STAT0, 8'hCF);
    $display("test behaviour and span done");
    temps(8'h40, 8'h40, 8'h40);
    wr(FPR_IDX_ACOU1, 8'hA0);
    rdc(FPR_IDX_STAT0, 8'h40);
    rdc(FPR_IDX_STAT1, 8'h00);
    rdc(FPR_IDX_STAT2, 8'h80);
    wr(FPR_IDX_ACOU1, 8'h50);
    rdc(FPR_IDX_STAT1, 8'h80);
    chk({29'h0, g_s}, 32'h7);
    wr(FPR_IDX_ACOU1, 8'h00);
    rdc(FPR_IDX_STAT1, 8'h00);
    chk({29'h0, g_s}, 32'h3);
    $display("test floor select done");
    for (int i = 0; i < 3; i++) wr(8'(FPR_IDX_SPAN1 + i), 8'h04);
    for (int i = 0; i < 8; i++) ramp(0, FPR_IDX_ACOU1, 8'h08 | 8'(i), 8'h01, incs[i], 16);
    ramp(0, FPR_IDX_ACOU1, 8'h08, 8'h00, 1, 4);
    ramp(0, FPR_IDX_ACOU1, 8'h08, 8'h80, 1, 6);
    ramp(0, FPR_IDX_ACOU1, 8'h08, 8'h81, 1, 24);
    ramp(1, FPR_IDX_REMOTE2_RAMP_RATE, 8'h0A, 8'h02, 3, 16);
    ramp(2, FPR_IDX_REMOTE2_RAMP_RATE, 8'hB0, 8'h04, 4, 16);
    $display("test ramp done");
    apb(1'b1, FPR_IDX_CTRL, 32'h11E);
    wr(FPR_IDX_STAT0, 8'h80);
    rdc(FPR_IDX_STAT0, 8'h80);
    wr(FPR_IDX_SPAN1, 8'hCC);
    repeat (200) @(posedge clk);
    inr(per[0], 43, 46);
    inr(2 * hi[0], int'(per[0]) - 3, int'(per[0]) + 3);
    wr(FPR_IDX_SPAN1, 8'hC7);
    repeat (30000) @(posedge clk);
    inr(per[0], 11200, 11480);
    $display("test drive frequency done");
    for (int i = 0; i < 8; i++) wr(8'(FPR_IDX_SPAN1 + i), 8'(8'h35 + i));
    for (int i = 0; i < 8; i++) rdc(8'(FPR_IDX_SPAN1 + i), 8'(8'h35 + i));
    apb(1'b1, FPR_IDX_CTRL, 32'h111);
    for (int i = 0; i < 8; i++) wr(8'(FPR_IDX_SPAN1 + i), 8'(8'hCA - i));
    for (int i = 0; i < 8; i++) rdc(8'(FPR_IDX_SPAN1 + i), 8'(8'h35 + i));
    $display("test lock done");
    end_sim();
  end
endmodule
`default_nettype wire
